/* File: verilog/ccr_pkg.sv */
`default_nettype none
// ------------------------------------------------------------
// shared constants of the coalescing / message register bank
// ------------------------------------------------------------
package ccr_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_COALESCE_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_PORT_SELECT = 8'h18;
    localparam logic [7:0] ADDR_BUF_LOCATION = 8'h1c;
    localparam logic [7:0] ADDR_MSG_CONTROL = 8'h20;

    // field positions
    localparam int LOC_OFFSET_LSB = 16;
    localparam int CTL_PM_BIT = 27;
    localparam int CTL_HW_LED_BIT = 26;
    localparam int CTL_XMT_ONLY_BIT = 25;
    localparam int CTL_SINGLE_BUF_BIT = 24;
    localparam int TRANSMIT_MESSAGE_REQUEST_BIT = 8;
    localparam int EN_BIT = 0;

    // values after reset
    localparam logic [31:0] PORT_SELECT_RST = 32'h0000_0000;
    localparam logic EN_RST = 1'b0;
    localparam logic TM_RST = 1'b0;

    // default buffer placement, in 32-bit words (plain values)
    localparam logic [15:0] BUF_WORD_OFFSET_DEF = 16'h0040;
    localparam logic [15:0] BUF_WORD_SIZE_DEF = 16'h0010;

    // timer tick: longest time, so it rounds down
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_TICK_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TIMER_TICK_NS / CLK_PERIOD_NS;

    localparam int NUM_PORTS = 32;
    localparam int BUF_ADDR_W = 20;

endpackage : ccr_pkg
`default_nettype wire

/* File: verilog/ccr_regs.sv */
// What this block does
// - each port select bit stands for one port, bit 0 for port 0, set means coalesced.
// - a newly written port selection is in use within one 1 ms timer tick.
// - completions are coalesced only for selected ports and only while enabled.
// - the upper half of the location register gives the fixed buffer word offset.
// - the lower half gives the fixed nonzero transmit buffer size in words.
// - transmit buffer sits at four times the offset, receive buffer right after it unless the single buffer bit is set.
// - a fixed bit tells whether port multiplier messages are supported.
// - with the hardware led bit set the activity led is made here, software value ignored.
// - after reset the hardware activity led stays off until the first transmit request.
// - a fixed bit tells transmit-only operation, which turns receiving off.
// - with the single buffer bit set one buffer serves both ways, no unsolicited receive.
// - with the single buffer bit clear separate buffers allow unsolicited receive, unless the transmit-only bit is set.
// - a transmit request sends the buffer and clears when sending is done.
`timescale 1ns/1ps
`default_nettype none

module ccr_regs
    import ccr_pkg::*;
#(
    parameter logic [15:0] BUF_WORD_OFFSET = BUF_WORD_OFFSET_DEF, // value arbitrary
    parameter logic [15:0] BUF_WORD_SIZE = BUF_WORD_SIZE_DEF, // nonzero
    parameter logic PM_SUPPORT = 1'b0, // port multiplier messages
    parameter logic HW_LED = 1'b1, // activity led from hardware
    parameter logic XMT_ONLY = 1'b0, // transmit only
    parameter logic SINGLE_BUF = 1'b0, // one shared buffer
    parameter int TICK_CYCLES = TICK_CYCLES_DEF // cycles per timer tick
) (
    input wire logic pclk, // controller clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [31:0] cmd_done, // per port completion pulses
    output logic [31:0] coalesced_done, // completions routed to coalescing
    output logic [31:0] direct_done, // completions reported directly
    output logic [31:0] coalesce_ports_active, // selection in use
    input wire logic msg_sent, // transport finished a message
    output logic msg_send_start, // pulse: start sending buffer
    output logic msg_busy, // transmit request pending
    input wire logic activity_in, // raw drive activity
    input wire logic sw_activity_led, // led value from software message
    output logic activity_led, // activity led drive
    output logic rx_enable, // receiving allowed
    output logic unsolicited_rx_enable, // unsolicited receive allowed
    output logic [19:0] tx_buf_byte_offset, // transmit buffer byte offset
    output logic [19:0] rx_buf_byte_offset // receive buffer byte offset
);

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic mapped;
    logic access;
    logic xfer_wr;

    assign access = psel & penable;
    // write lands on the edge that samples pready high
    assign xfer_wr = access & pready_q & pwrite & mapped;

    logic [31:0] sel_q;
    logic en_q;
    logic tm_q;
    logic armed_q;

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_COALESCE_ENABLE: rd_mux[EN_BIT] = en_q;
            ADDR_PORT_SELECT: rd_mux = sel_q;
            ADDR_BUF_LOCATION: rd_mux = {BUF_WORD_OFFSET, BUF_WORD_SIZE};
            ADDR_MSG_CONTROL: begin
                rd_mux[CTL_PM_BIT] = PM_SUPPORT;
                rd_mux[CTL_HW_LED_BIT] = HW_LED;
                rd_mux[CTL_XMT_ONLY_BIT] = XMT_ONLY;
                rd_mux[CTL_SINGLE_BUF_BIT] = SINGLE_BUF;
                rd_mux[TRANSMIT_MESSAGE_REQUEST_BIT] = tm_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // one wait state so every bus output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access & ~pready_q & ~pwrite) begin
                prdata_q <= rd_mux;
            end else if (~access) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // coalescing selection and enable
    // ------------------------------------------------------------
    logic wr_sel;
    logic wr_en;
    assign wr_sel = xfer_wr && (paddr == ADDR_PORT_SELECT);
    assign wr_en = xfer_wr && (paddr == ADDR_COALESCE_ENABLE);

    // byte strobes honoured on the selection word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= PORT_SELECT_RST;
        end else if (wr_sel) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    sel_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                end
            end
        end
    end

    // global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= EN_RST;
        end else if (wr_en && pstrb[0]) begin
            en_q <= pwdata[EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // timer tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [31:0] active_sel_q;

    // free running so a new selection never waits past one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    // selection switches only on a tick boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_sel_q <= PORT_SELECT_RST;
        end else if (tick_q) begin
            active_sel_q <= sel_q;
        end
    end

    // ------------------------------------------------------------
    // per port completion routing
    // ------------------------------------------------------------
    logic [31:0] coal_q;
    logic [31:0] direct_q;
    logic [31:0] act_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            // bit gi belongs to port gi
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    coal_q[gi] <= 1'b0;
                    direct_q[gi] <= 1'b0;
                    act_q[gi] <= 1'b0;
                end else begin
                    coal_q[gi] <= cmd_done[gi] & active_sel_q[gi] & en_q;
                    direct_q[gi] <= cmd_done[gi] & ~(active_sel_q[gi] & en_q);
                    act_q[gi] <= active_sel_q[gi] & en_q;
                end
            end
        end
    endgenerate

    assign coalesced_done = coal_q;
    assign direct_done = direct_q;
    assign coalesce_ports_active = act_q;

    // ------------------------------------------------------------
    // transmit request and activity led
    // ------------------------------------------------------------
    logic tm_set;
    logic start_q;
    logic led_q;
    assign tm_set = xfer_wr && (paddr == ADDR_MSG_CONTROL) && pstrb[1] && pwdata[TRANSMIT_MESSAGE_REQUEST_BIT];

    // a new request in the done cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tm_q <= TM_RST;
            start_q <= 1'b0;
        end else begin
            tm_q <= tm_set | (tm_q & ~msg_sent);
            start_q <= tm_set & (~tm_q | msg_sent);
        end
    end

    // armed by the first transmit request after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else if (tm_set) begin
            armed_q <= 1'b1;
        end
    end

    // hardware mode never looks at the software led value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_q <= 1'b0;
        end else if (HW_LED) begin
            led_q <= armed_q & activity_in;
        end else begin
            led_q <= sw_activity_led;
        end
    end

    assign msg_busy = tm_q;
    assign msg_send_start = start_q;
    assign activity_led = led_q;

    // ------------------------------------------------------------
    // buffer placement and direction
    // ------------------------------------------------------------
    logic rx_en_q;
    logic unsol_q;
    logic [19:0] tx_off_q;
    logic [19:0] rx_off_q;
    localparam logic [19:0] TX_OFF = {2'b00, BUF_WORD_OFFSET, 2'b00};
    localparam logic [19:0] SIZE_BYTES = {2'b00, BUF_WORD_SIZE, 2'b00};
    // shared buffer means receive uses the transmit area
    localparam logic [19:0] RX_OFF = SINGLE_BUF ? TX_OFF : TX_OFF + SIZE_BYTES;

    // fixed values, held in flops for clean outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_q <= ~XMT_ONLY;
            unsol_q <= ~XMT_ONLY & ~SINGLE_BUF;
            tx_off_q <= TX_OFF;
            rx_off_q <= RX_OFF;
        end else begin
            rx_en_q <= rx_en_q;
            unsol_q <= unsol_q;
            tx_off_q <= tx_off_q;
            rx_off_q <= rx_off_q;
        end
    end

    assign rx_enable = rx_en_q;
    assign unsolicited_rx_enable = unsol_q;
    assign tx_buf_byte_offset = tx_off_q;
    assign rx_buf_byte_offset = rx_off_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_loc;
    logic rd_ctl;
    assign rd_loc = access & pready_q & ~pwrite & (paddr == ADDR_BUF_LOCATION);
    assign rd_ctl = access & pready_q & ~pwrite & (paddr == ADDR_MSG_CONTROL);

    property p_route_split;
        ##1 ((coal_q | direct_q) == $past(cmd_done)) && ((coal_q & direct_q) == 32'h0);
    endproperty
    a_route_split: assert property (p_route_split) else $error("port routing wrong");

    property p_tick_bound;
        tick_cnt_q < 32'(TICK_CYCLES);
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("tick too late");

    property p_sel_apply;
        tick_q |=> active_sel_q == $past(sel_q);
    endproperty
    a_sel_apply: assert property (p_sel_apply) else $error("selection not applied");

    property p_disable;
        !en_q |=> coal_q == 32'h0 && act_q == 32'h0;
    endproperty
    a_disable: assert property (p_disable) else $error("coalesced while off");

    property p_loc_read;
        rd_loc |-> prdata_q[31:16] == BUF_WORD_OFFSET && prdata_q[15:0] != 16'h0;
    endproperty
    a_loc_read: assert property (p_loc_read) else $error("location read wrong");

    property p_rx_place;
        rx_off_q == (SINGLE_BUF ? tx_off_q : tx_off_q + {2'b00, BUF_WORD_SIZE, 2'b00})
            && tx_off_q == {2'b00, BUF_WORD_OFFSET, 2'b00};
    endproperty
    a_rx_place: assert property (p_rx_place) else $error("buffer placement wrong");

    property p_ctl_attr;
        rd_ctl |-> prdata_q[27:24] == {PM_SUPPORT, HW_LED, XMT_ONLY, SINGLE_BUF};
    endproperty
    a_ctl_attr: assert property (p_ctl_attr) else $error("attribute bits wrong");

    property p_led_hw;
        HW_LED && !activity_in |=> !led_q;
    endproperty
    a_led_hw: assert property (p_led_hw) else $error("software led leaked");

    property p_led_unarmed;
        (HW_LED && !armed_q) [*2] |-> !led_q;
    endproperty
    a_led_unarmed: assert property (p_led_unarmed) else $error("led before request");

    property p_dir;
        rx_en_q == !XMT_ONLY && (!SINGLE_BUF || !unsol_q);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");

    property p_unsol;
        (!SINGLE_BUF && !XMT_ONLY) |-> unsol_q;
    endproperty
    a_unsol: assert property (p_unsol) else $error("unsolicited off");

    property p_tm_clear;
        tm_q && msg_sent && !tm_set |=> !tm_q ##0 !msg_busy;
    endproperty
    a_tm_clear: assert property (p_tm_clear) else $error("request not cleared");

    property p_tm_start;
        tm_set && !tm_q |=> tm_q && start_q ##1 !start_q;
    endproperty
    a_tm_start: assert property (p_tm_start) else $error("send not started");

    c_send: cover property (start_q ##[1:20] msg_sent);
    c_coal: cover property (en_q && (coal_q != 32'h0));
    c_apply: cover property (wr_sel ##[1:40] tick_q);
    c_err: cover property (pslverr_q);

endmodule // ccr_regs
`default_nettype wire

/* File: verif/ccr_xport_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// message transport on the far side of the transmit request
// ------------------------------------------------------------
module ccr_xport_model (
    input wire logic pclk, // controller clock
    input wire logic presetn, // async reset, active low
    input wire logic msg_send_start, // start pulse from the bank
    input wire logic [7:0] send_cycles, // cycles a message takes
    output logic msg_sent // pulse: message done
);
    logic [7:0] cnt_q;
    logic run_q;

    // one message at a time; a start while busy is not queued, like the real link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            run_q <= 1'b0;
            msg_sent <= 1'b0;
        end else begin
            msg_sent <= 1'b0;
            if (msg_send_start && !run_q) begin
                run_q <= 1'b1;
                cnt_q <= send_cycles;
            end else if (run_q && cnt_q <= 8'h01) begin
                run_q <= 1'b0;
                msg_sent <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule // ccr_xport_model

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import ccr_pkg::*;
;
    localparam int TICK = 8;
    localparam logic [31:0] IMPL_PORTS = 32'h00ff_f0ff;
    localparam logic [31:0] ATTR = 32'h0400_0000; // hw led only
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, cmd_done = 32'h0;
    logic [31:0] prdata, coalesced_done, direct_done, coalesce_ports_active;
    logic msg_sent, msg_send_start, msg_busy, activity_led, rx_enable, unsol_rx;
    logic activity_in = 1'b0, sw_activity_led = 1'b0;
    logic pready, pslverr, e_s;
    logic [19:0] tx_off, rx_off;
    logic [7:0] send_cycles = 8'h1e;
    logic [31:0] lfsr = 32'h3f, sel_m, v;
    int n_errors = 0, n_compared = 0, n_start = 0;

    ccr_regs #(.TICK_CYCLES(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_done(cmd_done),
        .coalesced_done(coalesced_done), .direct_done(direct_done),
        .coalesce_ports_active(coalesce_ports_active), .msg_sent(msg_sent),
        .msg_send_start(msg_send_start), .msg_busy(msg_busy), .activity_in(activity_in),
        .sw_activity_led(sw_activity_led), .activity_led(activity_led),
        .rx_enable(rx_enable), .unsolicited_rx_enable(unsol_rx),
        .tx_buf_byte_offset(tx_off), .rx_buf_byte_offset(rx_off));

    ccr_xport_model u_xport (.pclk(pclk), .presetn(presetn), .msg_send_start(msg_send_start),
        .send_cycles(send_cycles), .msg_sent(msg_sent));

    always #25 pclk = ~pclk;

    // start pulses counted so a second request that is not refused shows up as an extra one
    always @(posedge pclk) if (msg_send_start === 1'b1) n_start++;

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // apb transfer: request held up to the rising edge that samples pready high;
    // no cycle count is assumed, only the watchdog ends a hung wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
        chk(er, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0, r, er);
        chk(r, exp);
        chk(er, e);
    endtask

    // bounded wait on the transmit request level
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (msg_busy !== lvl && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk(msg_busy, lvl);
    endtask

    task automatic reset_dut();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // completions with a fresh random pattern, checked one cycle later
    task automatic completions(input logic en);
        @(posedge pclk) cmd_done <= lfsr;
        v = lfsr;
        lfsr = nxt(lfsr);
        @(posedge pclk) cmd_done <= 32'h0;
        @(negedge pclk);
        chk(coalesced_done, en ? (v & sel_m) : 32'h0);
        chk(direct_done, en ? (v & ~sel_m) : v);
    endtask

    initial begin
        #(50 * 20000);
        n_errors++;
        test_done();
    end

    initial begin
        reset_dut();
        rd(ADDR_COALESCE_ENABLE, 32'h0, 1'b0);
        rd(ADDR_PORT_SELECT, PORT_SELECT_RST, 1'b0);
        rd(ADDR_BUF_LOCATION, {BUF_WORD_OFFSET_DEF, BUF_WORD_SIZE_DEF}, 1'b0);
        apb(1'b0, ADDR_BUF_LOCATION, 32'h0, v, e_s);
        chk(v[15:0] == 16'h0, 1'b0);
        wr(ADDR_BUF_LOCATION, 32'hffff_ffff, 1'b0);
        rd(ADDR_BUF_LOCATION, {BUF_WORD_OFFSET_DEF, BUF_WORD_SIZE_DEF}, 1'b0);
        wr(ADDR_MSG_CONTROL, 32'hff00_0000, 1'b0);
        rd(ADDR_MSG_CONTROL, ATTR, 1'b0);
        wr(8'h24, 32'h1234_5678, 1'b1);
        rd(8'h24, 32'h0, 1'b1);
        chk(tx_off, {BUF_WORD_OFFSET_DEF, 2'b00});
        chk(rx_off, {BUF_WORD_OFFSET_DEF, 2'b00} + {BUF_WORD_SIZE_DEF, 2'b00});
        chk(rx_enable, 1'b1);
        chk(unsol_rx, 1'b1);
        // led stays dark before the first transmit request, software value ignored
        activity_in <= 1'b1;
        sw_activity_led <= 1'b1;
        repeat (3) @(negedge pclk);
        chk(activity_led, 1'b0);
        // selection only on implemented ports, used only while enabled
        for (int i = 0; i < 4; i++) begin
            sel_m = lfsr & IMPL_PORTS;
            lfsr = nxt(lfsr);
            wr(ADDR_PORT_SELECT, sel_m, 1'b0);
            rd(ADDR_PORT_SELECT, sel_m, 1'b0);
            wr(ADDR_COALESCE_ENABLE, 32'h0, 1'b0);
            repeat (TICK + 2) @(posedge pclk);
            chk(coalesce_ports_active, 32'h0);
            completions(1'b0);
            wr(ADDR_COALESCE_ENABLE, 32'h1, 1'b0);
            repeat (TICK + 2) @(posedge pclk);
            @(negedge pclk);
            chk(coalesce_ports_active, sel_m);
            completions(1'b1);
        end
        // slow transport, then a prompt one; a second request while busy is refused
        for (int k = 0; k < 2; k++) begin
            n_start = 0;
            send_cycles <= k ? 8'h01 : 8'h1e;
            wr(ADDR_MSG_CONTROL, 32'h0000_0100, 1'b0);
            wait_busy(1'b1, 4);
            if (k == 0) begin
                rd(ADDR_MSG_CONTROL, ATTR | 32'h0100, 1'b0);
                wr(ADDR_MSG_CONTROL, 32'h0000_0100, 1'b0);
                wr(ADDR_MSG_CONTROL, 32'h0, 1'b0);
            end
            wait_busy(1'b0, 100);
            chk(n_start, 1);
            rd(ADDR_MSG_CONTROL, ATTR, 1'b0);
        end
        // hardware led now follows activity one cycle late
        for (int j = 0; j < 4; j++) begin
            @(posedge pclk) activity_in <= j[0];
            sw_activity_led <= ~j[0];
            @(posedge pclk);
            @(negedge pclk);
            chk(activity_led, j[0]);
        end
        // a second reset disarms the led and clears the selection again
        @(posedge pclk);
        activity_in <= 1'b1;
        reset_dut();
        repeat (3) @(negedge pclk);
        chk(activity_led, 1'b0);
        chk(msg_busy, 1'b0);
        rd(ADDR_PORT_SELECT, PORT_SELECT_RST, 1'b0);
        test_done();
    end
endmodule // tb_top

`default_nettype wire
